// file: logic/uart_pkg.sv
// shared constants, register layout and state types for the serial block
package uart_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] CTRL1_OFS = 8'h00;
  localparam logic [7:0] CTRL2_OFS = 8'h04;
  localparam logic [7:0] STAT1_OFS = 8'h08;
  localparam logic [7:0] STAT2_OFS = 8'h0c;
  localparam logic [7:0] CTRL3_OFS = 8'h10;
  localparam logic [7:0] DATA_OFS  = 8'h14;
  localparam logic [7:0] BAUD_OFS  = 8'h18;

  // control_reg_1 fields
  localparam int C1_PAR_ODD = 0;
  localparam int C1_PAR_EN  = 1;
  localparam int C1_ILT     = 2;
  localparam int C1_WAKE    = 3;
  localparam int C1_NINE    = 4;
  localparam int C1_RX_SOURCE_SELECT    = 5;
  localparam int C1_LOOP    = 7;
  localparam logic [7:0] C1_WMASK = 8'hbf;

  // control_reg_2 fields
  localparam int C2_SLEEP  = 1;
  localparam int C2_RX_ON  = 2;
  localparam int C2_TX_ON  = 3;
  localparam int C2_IDL_IE = 4;
  localparam int C2_RXF_IE = 5;
  localparam int C2_TXD_IE = 6;
  localparam int C2_TXE_IE = 7;
  localparam logic [7:0] C2_WMASK = 8'hfe;

  // status_reg_2 fields
  localparam int S2_BRK_IE  = 0;
  localparam int S2_EDGE_IE = 1;
  localparam int S2_IDL_SLP = 2;
  localparam int S2_EDGE    = 6;
  localparam int S2_BRK     = 7;

  // control_reg_3 fields
  localparam int C3_PAR_IE = 0;
  localparam int C3_FRM_IE = 1;
  localparam int C3_NF_IE  = 2;
  localparam int C3_OVR_IE = 3;
  localparam int C3_DIR    = 5;
  localparam int C3_TX9    = 6;
  localparam int C3_RX9    = 7;
  localparam logic [7:0] C3_WMASK = 8'h6f;

  localparam int unsigned BAUD_W   = 13;
  localparam logic [12:0] BAUD_RST = 13'h000d;

  // frame lengths and 16x sample points
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [3:0] CHAR_BITS_8 = 4'ha;
  localparam logic [3:0] CHAR_BITS_9 = 4'hb;
  localparam logic [3:0] RT_START    = 4'h6;
  localparam logic [3:0] RT_S1       = 4'h7;
  localparam logic [3:0] RT_S2       = 4'h8;
  localparam logic [3:0] RT_S3       = 4'h9;
  localparam logic [3:0] RT_LAST     = 4'hf;

  localparam logic [1:0] STOP_RUN   = 2'b00;
  localparam logic [1:0] STOP_LIGHT = 2'b01;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;

  typedef struct packed {
    logic tx_empty;
    logic tx_done;
    logic rx_full;
    logic idle;
    logic overrun;
    logic noise;
    logic frame;
    logic parity;
  } stat1_t;

  typedef struct packed {
    logic tx;
    logic rx;
    logic err;
  } irq_t;

  typedef struct packed {
    logic [10:0] sh;
    logic [3:0]  cnt;
    logic        busy;
    logic        line;
  } tx_state_t;

  localparam tx_state_t TX_RST = '{sh: 11'h000, cnt: 4'h0, busy: 1'b0,
                                   line: 1'b1};

  typedef struct packed {
    logic [7:0]  c1;
    logic [7:0]  c2;
    logic [7:0]  c3;
    logic [2:0]  en2;
    stat1_t      s1;
    logic [5:0]  seen;
    logic        edge_f;
    logic        brk_f;
    logic [7:0]  rx_data;
    logic [7:0]  tx_buf;
    logic        tx_full;
    logic [12:0] baud;
    logic [12:0] bcnt;
    logic        tick;
    logic [3:0]  txph;
    logic [2:0]  sy_in;
    logic [2:0]  sy_sw;
    logic        lv_in;
    logic        lv_sw;
    logic        edge_prev;
    logic        rx_prev;
    rx_state_t   rxs;
    logic [3:0]  rph;
    logic [3:0]  rbit;
    logic [8:0]  rsh;
    logic [1:0]  samp;
    logic        rnoise;
    logic [3:0]  icnt;
    logic [3:0]  iph;
    logic        armed;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    irq_t        irq;
    logic        wake;
    logic        out_o;
    logic        out_oe;
    logic        in_release;
  } uart_state_t;

  localparam uart_state_t STATE_RST = '{
    s1: 8'hc0, baud: BAUD_RST, sy_in: 3'h7, sy_sw: 3'h7, lv_in: 1'b1,
    lv_sw: 1'b1, edge_prev: 1'b1, rx_prev: 1'b1, rxs: RX_IDLE,
    out_o: 1'b1, out_oe: 1'b1, default: '0};
endpackage

// file: logic/tx_shifter.sv
// transmit shift register producing start, data and stop bits lsb first
`timescale 1ns/1ps
module tx_shifter (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       flush,
  input  wire logic       bit_tick,
  input  wire logic       load,
  input  wire logic [8:0] load_data,
  input  wire logic       nine,
  output logic            busy,
  output logic            line
);
  uart_pkg::tx_state_t q;
  uart_pkg::tx_state_t d;

  always_comb begin
    d = q;
    if (load && !q.busy) begin
      // frame: start 0, data lsb first, stop 1
      d.sh   = nine ? {1'b1, load_data, 1'b0}
                    : {2'b11, load_data[7:0], 1'b0};
      d.cnt  = nine ? uart_pkg::CHAR_BITS_9 : uart_pkg::CHAR_BITS_8;
      d.busy = 1'b1;
    end else if (bit_tick && q.busy) begin
      if (q.cnt != 4'h0) begin
        d.line = q.sh[0];
        d.sh   = {1'b1, q.sh[10:1]};
        d.cnt  = q.cnt - 4'h1;
      end else begin
        // stop bit has had its full time; line rests high
        d.busy = 1'b0;
        d.line = 1'b1;
      end
    end
    if (flush) begin
      d = uart_pkg::TX_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= uart_pkg::TX_RST;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign line = q.line;
endmodule

// file: logic/uart_core.sv
// serial interface core: apb registers, receiver, flags, wake and loop modes
// Behaviour
// - while sleeping no receiver flag sets, except idle when idle-in-sleep enabled
// - idle-line wake clears sleep after 10 or 11 idle bit times
// - sleeping without idle-in-sleep, the waking idle does not set idle flag
// - with idle-in-sleep enabled an armed idle detection sets idle while sleeping; interrupts while enabled
// - idle counting starts after start bit, or after stop bit when selected
// - address-mark wake clears sleep when received msb is one
// - three interrupt requests from ten individually masked sources
// - tx empty shows buffer room and requests transmit interrupt while enabled
// - tx done only when all sent and line idle; interrupts while enabled
// - rx full clears by status read while set, then data read
// - idle clears the same way and waits for a new character to rearm
// - noise, framing and parity flags set with rx full, never on overrun
// - character arriving while rx full sets overrun and is discarded
// - with receiver on an active edge sets edge flag; write one clears it
// - nine-bit select gives nine-bit characters via the ninth-bit fields
// - tx ninth bit is copied into the shifter with the data
// - stop modes halt the block; deep ones lose state, light keeps it
// - edge detector works in light stop and wakes when enabled
// - loop mode feeds transmitter output to receiver and frees input pin
// - single-wire mode takes receiver input from transmitter and output pin
// - in single-wire mode direction zero makes output pin an input; one lets transmitter drive
// - in single-wire mode with direction one the receiver hears its own transmitter
// - frame is start zero, eight or nine data bits lsb first, stop one
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module uart_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_in_pin,
  input  wire logic        serial_out_pin_i,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe,
  output logic             serial_in_release,
  input  wire logic [1:0]  stop_mode,
  output uart_pkg::irq_t   irq,
  output logic             wake_req
);
  uart_pkg::uart_state_t q;
  uart_pkg::uart_state_t d;
  uart_pkg::uart_state_t frozen;

  logic       tx_busy;
  logic       tx_line;
  logic       tx_load;
  logic       bit_tick;
  logic       run;
  logic       rx_in;
  logic       loop;
  logic       rx_source_select;
  logic       dir;
  logic       nine;
  logic       sleep;
  logic       rx_on;
  logic       acc;
  logic       setup;
  logic [5:0] rd_clr;
  logic       clr_edge;
  logic       clr_brk;
  logic       clr_tc;
  logic       bitv;
  logic       noisy;
  logic       deliver;
  logic       frame_c;
  logic       noise_c;
  logic       par_bad;
  logic [8:0] char9;
  logic [3:0] nbits;
  logic [3:0] thr;
  logic       idle_hold;
  logic       idle_evt;

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      uart_pkg::CTRL1_OFS, uart_pkg::CTRL2_OFS, uart_pkg::STAT1_OFS,
      uart_pkg::STAT2_OFS, uart_pkg::CTRL3_OFS, uart_pkg::DATA_OFS,
      uart_pkg::BAUD_OFS: mapped = 1'b1;
      default:            mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] reg_read(input uart_pkg::uart_state_t s,
                                           input logic [7:0] a);
    case (a)
      uart_pkg::CTRL1_OFS: reg_read = {24'h0, s.c1};
      uart_pkg::CTRL2_OFS: reg_read = {24'h0, s.c2};
      uart_pkg::STAT1_OFS: reg_read = {24'h0, s.s1};
      uart_pkg::STAT2_OFS: reg_read = {24'h0, s.brk_f, s.edge_f, 3'h0, s.en2};
      uart_pkg::CTRL3_OFS: reg_read = {24'h0, s.c3};
      uart_pkg::DATA_OFS:  reg_read = {24'h0, s.rx_data};
      uart_pkg::BAUD_OFS:  reg_read = {19'h0, s.baud};
      default:             reg_read = 32'h0;
    endcase
  endfunction

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  always_comb begin
    d         = q;
    frozen    = q;
    run       = (stop_mode == uart_pkg::STOP_RUN);
    loop      = q.c1[uart_pkg::C1_LOOP];
    rx_source_select      = q.c1[uart_pkg::C1_RX_SOURCE_SELECT];
    dir       = q.c3[uart_pkg::C3_DIR];
    nine      = q.c1[uart_pkg::C1_NINE];
    sleep     = q.c2[uart_pkg::C2_SLEEP];
    rx_on     = q.c2[uart_pkg::C2_RX_ON];
    nbits     = nine ? uart_pkg::DATA_BITS_9 : uart_pkg::DATA_BITS_8;
    thr       = nine ? uart_pkg::CHAR_BITS_9 : uart_pkg::CHAR_BITS_8;
    setup     = psel && !penable;
    acc       = psel && penable && q.pready;
    rd_clr    = 6'h00;
    clr_edge  = 1'b0;
    clr_brk   = 1'b0;
    clr_tc    = 1'b0;
    bitv      = 1'b0;
    noisy     = 1'b0;
    deliver   = 1'b0;
    frame_c   = 1'b0;
    noise_c   = 1'b0;
    idle_evt  = 1'b0;
    idle_hold = 1'b0;
    tx_load   = 1'b0;
    bit_tick  = q.tick && (q.txph == uart_pkg::RT_LAST);
    char9     = nine ? q.rsh : {1'b0, q.rsh[7:0]};
    par_bad   = q.c1[uart_pkg::C1_PAR_EN] &&
                ((^char9) != q.c1[uart_pkg::C1_PAR_ODD]);

    // pin inputs: three stages, level moves when stages two and three agree
    d.sy_in = {q.sy_in[1:0], serial_in_pin};
    d.sy_sw = {q.sy_sw[1:0], serial_out_pin_i};
    if (q.sy_in[1] == q.sy_in[2]) begin
      d.lv_in = q.sy_in[2];
    end
    if (q.sy_sw[1] == q.sy_sw[2]) begin
      d.lv_sw = q.sy_sw[2];
    end

    // receiver source and pin ownership
    if (!loop) begin
      rx_in = q.lv_in;
    end else if (!rx_source_select) begin
      rx_in = tx_line;
    end else begin
      rx_in = dir ? tx_line : q.lv_sw;
    end
    d.in_release = loop;
    d.out_oe     = !(loop && rx_source_select && !dir);
    d.out_o      = tx_line;

    // 16x sample tick from the divisor
    if (q.bcnt == 13'h0000) begin
      d.bcnt = q.baud - 13'h0001;
      d.tick = 1'b1;
    end else begin
      d.bcnt = q.bcnt - 13'h0001;
      d.tick = 1'b0;
    end
    if (q.tick) begin
      d.txph = q.txph + 4'h1;
    end

    // apb: answer is registered, so outside stop modes every transfer has one wait-free access
    d.pready  = setup;
    d.pslverr = setup && !mapped(paddr);
    if (setup) begin
      d.prdata = reg_read(q, paddr);
    end
    if (acc && pwrite) begin
      case (paddr)
        uart_pkg::CTRL1_OFS: d.c1 = pwdata[7:0] & uart_pkg::C1_WMASK;
        uart_pkg::CTRL2_OFS: d.c2 = pwdata[7:0] & uart_pkg::C2_WMASK;
        uart_pkg::CTRL3_OFS: d.c3 = (pwdata[7:0] & uart_pkg::C3_WMASK) |
                                    (q.c3 & ~uart_pkg::C3_WMASK);
        uart_pkg::STAT2_OFS: begin
          d.en2    = pwdata[2:0];
          clr_edge = pwdata[uart_pkg::S2_EDGE];
          clr_brk  = pwdata[uart_pkg::S2_BRK];
        end
        uart_pkg::DATA_OFS: begin
          // a write while the buffer is full is dropped
          if (!q.tx_full) begin
            d.tx_buf  = pwdata[7:0];
            d.tx_full = 1'b1;
            clr_tc    = 1'b1;
          end
        end
        uart_pkg::BAUD_OFS: d.baud = pwdata[12:0];
        default: ;
      endcase
    end
    if (acc && !pwrite) begin
      case (paddr)
        uart_pkg::STAT1_OFS: d.seen = q.s1[5:0];
        uart_pkg::DATA_OFS: begin
          rd_clr = q.seen;
          d.seen = 6'h00;
        end
        default: ;
      endcase
    end

    // clears first, so a hardware set later in this pass wins
    d.s1 = uart_pkg::stat1_t'(q.s1 & ~{2'b00, rd_clr});
    if (clr_edge) begin
      d.edge_f = 1'b0;
    end
    if (clr_brk) begin
      d.brk_f = 1'b0;
    end

    // transmitter: ninth bit travels with the buffer into the shifter
    tx_load = q.tx_full && !tx_busy && q.c2[uart_pkg::C2_TX_ON] && run;
    if (tx_load) begin
      d.tx_full = 1'b0;
    end
    d.s1.tx_empty = !d.tx_full;
    if (clr_tc) begin
      d.s1.tx_done = 1'b0;
    end
    if (!tx_busy && !d.tx_full && !tx_load) begin
      d.s1.tx_done = 1'b1;
    end

    // active edge on the receive input
    d.edge_prev = rx_in;
    if (q.edge_prev && !rx_in && rx_on && !sleep) begin
      d.edge_f = 1'b1;
    end

    // receive state machine, one step per 16x tick
    if (!rx_on) begin
      d.rxs  = uart_pkg::RX_IDLE;
      d.icnt = 4'h0;
      d.iph  = 4'h0;
    end else if (q.tick) begin
      d.rx_prev = rx_in;
      d.rph     = q.rph + 4'h1;
      if (q.rph == uart_pkg::RT_S1) begin
        d.samp[0] = rx_in;
      end
      if (q.rph == uart_pkg::RT_S2) begin
        d.samp[1] = rx_in;
      end
      bitv  = maj3(q.samp[0], q.samp[1], rx_in);
      noisy = !((q.samp[0] == q.samp[1]) && (q.samp[1] == rx_in));
      case (q.rxs)
        uart_pkg::RX_IDLE: begin
          d.rph = 4'h0;
          if (q.rx_prev && !rx_in) begin
            d.rxs = uart_pkg::RX_START;
          end
        end
        uart_pkg::RX_START: begin
          if (q.rph == uart_pkg::RT_START && rx_in) begin
            d.rxs = uart_pkg::RX_IDLE;           // glitch, not a start bit
          end else if (q.rph == uart_pkg::RT_LAST) begin
            d.rxs    = uart_pkg::RX_DATA;
            d.rbit   = 4'h0;
            d.rsh    = 9'h000;
            d.rnoise = 1'b0;
          end
        end
        uart_pkg::RX_DATA: begin
          if (q.rph == uart_pkg::RT_S3) begin
            d.rsh[q.rbit] = bitv;
            d.rbit        = q.rbit + 4'h1;
            d.rnoise      = q.rnoise | noisy;
            if (q.rbit == nbits - 4'h1 && bitv && sleep &&
                q.c1[uart_pkg::C1_WAKE]) begin
              d.c2[uart_pkg::C2_SLEEP] = 1'b0;
            end
          end
          if (q.rph == uart_pkg::RT_LAST && q.rbit == nbits) begin
            d.rxs = uart_pkg::RX_STOP;
          end
        end
        uart_pkg::RX_STOP: begin
          if (q.rph == uart_pkg::RT_S3) begin
            deliver = 1'b1;
            frame_c = !bitv;
            noise_c = q.rnoise | noisy;
            d.rxs   = uart_pkg::RX_IDLE;
          end
        end
        default: d.rxs = uart_pkg::RX_IDLE;
      endcase

      // idle-line counter in whole bit times
      if (q.c1[uart_pkg::C1_ILT]) begin
        idle_hold = (q.rxs != uart_pkg::RX_IDLE);
      end else begin
        idle_hold = (q.rxs == uart_pkg::RX_START);
      end
      if (!rx_in || idle_hold) begin
        d.icnt = 4'h0;
        d.iph  = 4'h0;
      end else begin
        d.iph = q.iph + 4'h1;
        if (q.iph == uart_pkg::RT_LAST && q.icnt != thr) begin
          d.icnt   = q.icnt + 4'h1;
          idle_evt = (q.icnt + 4'h1 == thr);
        end
      end
    end

    // character hand-over from the shifter to the buffer
    if (deliver && !sleep) begin
      if (d.s1.rx_full) begin
        d.s1.overrun = 1'b1;
      end else begin
        d.s1.rx_full = 1'b1;
        d.rx_data    = char9[7:0];
        d.c3[uart_pkg::C3_RX9] = char9[8];
        d.s1.noise   = d.s1.noise | noise_c;
        d.s1.frame   = d.s1.frame | frame_c;
        d.s1.parity  = d.s1.parity | par_bad;
        d.armed      = 1'b1;
      end
      if (frame_c && char9 == 9'h000) begin
        d.brk_f = 1'b1;
      end
    end

    if (idle_evt) begin
      if (sleep && !q.c1[uart_pkg::C1_WAKE]) begin
        d.c2[uart_pkg::C2_SLEEP] = 1'b0;
      end
      if (q.armed && (!sleep || q.en2[uart_pkg::S2_IDL_SLP])) begin
        d.s1.idle = 1'b1;
        d.armed   = 1'b0;
      end
    end

    // three grouped requests, one mask per source
    d.irq.tx  = (d.s1.tx_empty & q.c2[uart_pkg::C2_TXE_IE]) |
                (d.s1.tx_done & q.c2[uart_pkg::C2_TXD_IE]);
    d.irq.rx  = (d.s1.rx_full & q.c2[uart_pkg::C2_RXF_IE]) |
                (d.s1.idle & q.c2[uart_pkg::C2_IDL_IE]) |
                (d.edge_f & q.en2[uart_pkg::S2_EDGE_IE]) |
                (d.brk_f & q.en2[uart_pkg::S2_BRK_IE]);
    d.irq.err = (d.s1.overrun & q.c3[uart_pkg::C3_OVR_IE]) |
                (d.s1.noise & q.c3[uart_pkg::C3_NF_IE]) |
                (d.s1.frame & q.c3[uart_pkg::C3_FRM_IE]) |
                (d.s1.parity & q.c3[uart_pkg::C3_PAR_IE]);
    d.wake = (stop_mode == uart_pkg::STOP_LIGHT) && d.edge_f &&
             q.en2[uart_pkg::S2_EDGE_IE];

    // stop modes: light keeps all but the edge path, deep loses everything
    if (stop_mode[1]) begin
      d = uart_pkg::STATE_RST;
    end else if (stop_mode == uart_pkg::STOP_LIGHT) begin
      frozen.sy_in     = d.sy_in;
      frozen.sy_sw     = d.sy_sw;
      frozen.lv_in     = d.lv_in;
      frozen.lv_sw     = d.lv_sw;
      frozen.edge_prev = d.edge_prev;
      frozen.edge_f    = d.edge_f;
      frozen.irq.rx    = d.irq.rx;
      frozen.wake      = d.wake;
      d = frozen;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= uart_pkg::STATE_RST;
    end else begin
      q <= d;
    end
  end

  tx_shifter u_tx (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (stop_mode[1]),
    .bit_tick  (bit_tick && run),
    .load      (tx_load),
    .load_data ({q.c3[uart_pkg::C3_TX9], q.tx_buf}),
    .nine      (nine),
    .busy      (tx_busy),
    .line      (tx_line)
  );

  assign prdata            = q.prdata;
  assign pready            = q.pready;
  assign pslverr           = q.pslverr;
  assign serial_out_pin_o  = q.out_o;
  assign serial_out_pin_oe = q.out_oe;
  assign serial_in_release = q.in_release;
  assign irq               = q.irq;
  assign wake_req          = q.wake;
endmodule

// file: verif/uart_core_properties.sv
// assertions on the serial core ports
`timescale 1ns/1ps
module uart_core_properties (
  input logic           pclk,
  input logic           presetn,
  input logic           psel,
  input logic           penable,
  input logic           pwrite,
  input logic [7:0]     paddr,
  input logic [31:0]    pwdata,
  input logic           pready,
  input logic           pslverr,
  input logic           serial_out_pin_o,
  input logic           serial_out_pin_oe,
  input logic           serial_in_release,
  input logic [1:0]     stop_mode,
  input uart_pkg::irq_t irq,
  input logic           wake_req
);
  logic [17:0] sh_q;
  logic        wr;
  assign wr = psel && penable && pready && pwrite;
  // mirror of mode bits; deep stop wipes them as it wipes the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= '0;
    end else if (stop_mode[1]) begin
      sh_q <= '0;
    end else if (wr && paddr == 8'h00) begin
      sh_q[7:0] <= pwdata[7:0];
    end else if (wr && paddr == 8'h10) begin
      sh_q[15:8] <= pwdata[7:0];
    end else if (wr && paddr == 8'h04) begin
      sh_q[17:16] <= pwdata[7:6];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PRDY: assert property (
    psel && !penable && !stop_mode ##1 !stop_mode |-> pready)
    else $error("access not answered");
  AST_ONE: assert property (
    pready |=> !pready) else $error("ready too long");
  AST_ERR: assert property (
    pslverr |-> pready) else $error("error without ready");
  AST_WAKE: assert property (
    wake_req |-> $past(stop_mode) == 2'b01) else $error("wake outside stop");
  AST_DEEP: assert property (
    stop_mode[1] |=> irq == '0 && serial_out_pin_o && !serial_in_release)
    else $error("deep stop kept state");
  AST_HOLD: assert property (
    (stop_mode == 2'b01) [*2] |-> $stable(serial_out_pin_o))
    else $error("line moved in light stop");
  AST_TXI: assert property (
    (sh_q[17:16] == 2'b00) [*3] |-> !irq.tx)
    else $error("tx request while masked");
  AST_REL: assert property (
    sh_q[7] [*2] |-> serial_in_release) else $error("rx pin not freed");
  AST_OE: assert property (
    (sh_q[7] && sh_q[5] && !sh_q[13]) [*2] |-> !serial_out_pin_oe)
    else $error("tx pin driven as input");
  cover property (wake_req);
  cover property (pslverr);
  cover property (serial_in_release && !serial_out_pin_oe);
endmodule

// file: verif/serial_node.sv
// remote serial node on the receive line and far end of the tx pin
`timescale 1ns/1ps
module serial_node #(parameter int BIT_CYC = 16) (
  input  logic tx_o,
  input  logic tx_oe,
  input  logic pclk,
  output logic rx_line,
  output logic tx_pin
);
  logic drv = 1'b1;
  assign rx_line = drv;
  // undriven tx pin shows the far node, idling at the pull-up level
  assign tx_pin = tx_oe ? tx_o : drv;
  task automatic send(input logic [8:0] d, input logic nine,
                      input logic stop);
    logic [10:0] f;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge pclk);
      drv <= f[i];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
    @(posedge pclk);
    drv <= 1'b1;
  endtask
endmodule

// file: verif/serial_comms_rx_wake_flags_modes_tb.sv
// self-checking bench for the serial core
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
  num_checks++; \
  if ((s) !== (e)) begin \
    fails++; \
    $display("Error %s expected %h seen %h", n, e, s); \
  end \
end
module serial_comms_rx_wake_flags_modes_tb;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} row_t;
  logic           pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic           penable = 1'b0, pwrite = 1'b0, err_s;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0, prdata, rd;
  logic           pready, pslverr, rx_pin, pin_i, pin_o, pin_oe, rel;
  logic [1:0]     stop_mode = 2'b00;
  uart_pkg::irq_t irq;
  logic           wake_req;
  int             fails = 0, num_checks = 0;
  row_t rows [7] = '{'{8'h00, 32'h0, 1'b0}, '{8'h04, 32'h0, 1'b0},
    '{8'h08, 32'hc0, 1'b0}, '{8'h0c, 32'h0, 1'b0}, '{8'h10, 32'h0, 1'b0},
    '{8'h18, 32'h0d, 1'b0}, '{8'h1c, 32'h0, 1'b1}};
  always #20 pclk = ~pclk;
  uart_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(rx_pin), .serial_out_pin_i(pin_i),
    .serial_out_pin_o(pin_o), .serial_out_pin_oe(pin_oe),
    .serial_in_release(rel), .stop_mode(stop_mode), .irq(irq),
    .wake_req(wake_req));
  serial_node node (.pclk(pclk), .tx_o(pin_o), .tx_oe(pin_oe),
    .rx_line(rx_pin), .tx_pin(pin_i));
  task automatic complete_run;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err_s = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      complete_run;
    end
    @(posedge pclk);
  endtask
  task automatic bits(input int n);
    repeat (n * 16) @(posedge pclk);
  endtask
  task automatic wait_full;
    int k;
    for (k = 0; k < 300; k++) begin
      apb(1'b0, 8'h08, 32'h0);
      if (rd[5] === 1'b1) break;
    end
    if (k == 300) begin
      fails++;
      complete_run;
    end
  endtask
  task automatic flush;
    bits(12);
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      `CHK("reset value", rows[i].d, rd)
      `CHK("slave error", rows[i].e, err_s)
    end
    $display("test reset done");
    apb(1'b1, 8'h18, 32'h1);
    apb(1'b1, 8'h04, 32'h0c);
    node.send(9'h0a5, 1'b0, 1'b1);
    wait_full;
    apb(1'b0, 8'h14, 32'h0);
    `CHK("rx data", 32'ha5, rd)
    apb(1'b0, 8'h08, 32'h0);
    `CHK("full clear", 1'b0, rd[5])
    bits(12);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("idle set", 1'b1, rd[4])
    flush;
    apb(1'b0, 8'h08, 32'h0);
    `CHK("idle rearm", 32'hc0, rd & 32'hd0)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("edge flag", 1'b1, rd[6])
    apb(1'b1, 8'h0c, 32'h40);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("edge clear", 1'b0, rd[6])
    node.send(9'h011, 1'b0, 1'b1);
    node.send(9'h033, 1'b0, 1'b0);
    bits(1);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("overrun", 2'b10, {rd[3], rd[1]})
    apb(1'b0, 8'h14, 32'h0);
    `CHK("kept data", 32'h11, rd)
    flush;
    $display("test receive done");
    apb(1'b1, 8'h00, 32'h08);
    apb(1'b1, 8'h04, 32'h0e);
    node.send(9'h012, 1'b0, 1'b1);
    bits(1);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("asleep", 1'b0, rd[5])
    node.send(9'h092, 1'b0, 1'b1);
    wait_full;
    apb(1'b0, 8'h14, 32'h0);
    `CHK("mark data", 32'h92, rd)
    apb(1'b0, 8'h04, 32'h0);
    `CHK("mark wake", 32'h0c, rd)
    flush;
    apb(1'b1, 8'h00, 32'h0);
    // sleep is set mid-frame so the waking idle stretch is a fresh one;
    // the first character arms the idle flag before sleep begins
    fork
      begin
        node.send(9'h001, 1'b0, 1'b1);
        node.send(9'h000, 1'b0, 1'b1);
      end
      begin
        bits(13);
        apb(1'b1, 8'h04, 32'h0e);
      end
    join
    bits(12);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("idle wake", 1'b0, rd[1])
    apb(1'b0, 8'h08, 32'h0);
    `CHK("wake no idle", 1'b0, rd[4])
    flush;
    $display("test sleep done");
    apb(1'b1, 8'h10, 32'h40);
    apb(1'b1, 8'h00, 32'h90);
    apb(1'b1, 8'h14, 32'h3c);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("tx busy", 1'b0, rd[6])
    wait_full;
    apb(1'b0, 8'h14, 32'h0);
    `CHK("loop data", 32'h3c, rd)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("ninth bit", 1'b1, rd[7])
    bits(2);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("tx done", 2'b11, rd[7:6])
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'ha0);
    node.send(9'h077, 1'b0, 1'b1);
    wait_full;
    apb(1'b0, 8'h14, 32'h0);
    `CHK("wire in", 32'h77, rd)
    $display("test loop done");
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h0c, 32'h42);
    stop_mode <= 2'b01;
    node.send(9'h055, 1'b0, 1'b1);
    `CHK("stop wake", 1'b1, wake_req)
    stop_mode <= 2'b00;
    apb(1'b0, 8'h04, 32'h0);
    `CHK("retained", 32'h0c, rd)
    stop_mode <= 2'b10;
    repeat (2) @(posedge pclk);
    stop_mode <= 2'b00;
    apb(1'b0, 8'h04, 32'h0);
    `CHK("deep lost", 32'h0, rd)
    $display("test stop done");
    complete_run;
  end
endmodule
bind uart_core uart_core_properties chk (.*);
